// >>> core/file_alu_pkg.sv
/*
  Shared constants for the file-register operation datapath: widths,
  operation codes, destination encodings, register-port offsets, flag
  positions and reset values.
  Assumes the two design files refer to every item as file_alu_pkg::name.
*/
package file_alu_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int OP_W       = 3;
  localparam int REG_ADDR_W = 2;

  // ---------------------------------------------------------------
  // operation codes presented by the decoder
  // ---------------------------------------------------------------
  localparam logic [OP_W-1:0] REG_INCREMENT_OP       = 3'h0;
  localparam logic [OP_W-1:0] ACC_OR_REG_OP          = 3'h1;
  localparam logic [OP_W-1:0] LOGICAL_SHIFT_LEFT_OP  = 3'h2;
  localparam logic [OP_W-1:0] LOGICAL_SHIFT_RIGHT_OP = 3'h3;
  localparam logic [OP_W-1:0] REG_MOVE_TEST_OP       = 3'h4;

  // ---------------------------------------------------------------
  // destination select encodings
  // ---------------------------------------------------------------
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ---------------------------------------------------------------
  // bit positions inside a data byte
  // ---------------------------------------------------------------
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;

  // ---------------------------------------------------------------
  // register port map and flag layout
  // ---------------------------------------------------------------
  localparam logic [REG_ADDR_W-1:0] REG_ACC_OFS   = 2'h0;
  localparam logic [REG_ADDR_W-1:0] REG_FLAGS_OFS = 2'h1;
  localparam int                    FLAG_C_POS    = 0;
  localparam int                    FLAG_Z_POS    = 1;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic              C_RESET    = 1'b0;
  localparam logic              Z_RESET    = 1'b0;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;

  // zero test of a result byte
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    is_zero = (value == BYTE_ZERO);
  endfunction

endpackage

// >>> core/file_alu_unit.sv
/*
  Combinational result unit: computes result, carry and flag-update
  enables for one file-register operation.
  Assumes operands are stable for the cycle in which it is sampled.
*/
`timescale 1ns/1ps
`default_nettype none

module file_alu_unit (
  // operation and operands
  input  wire logic [2:0] op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] src,
  // result and flag updates
  output logic      [7:0] result,
  output logic            carry,
  output logic            carry_upd,
  output logic            zero_upd
);

  // ---------------------------------------------------------------
  // operation select
  // ---------------------------------------------------------------

  // result and flags per operation
  always_comb begin
    result    = src;
    carry     = 1'b0;
    carry_upd = 1'b0;
    zero_upd  = 1'b0;
    case (op)
      file_alu_pkg::REG_INCREMENT_OP: begin
        result   = src + file_alu_pkg::BYTE_ONE;
        zero_upd = 1'b1;
      end
      file_alu_pkg::ACC_OR_REG_OP: begin
        result   = acc | src;
        zero_upd = 1'b1;
      end
      file_alu_pkg::LOGICAL_SHIFT_LEFT_OP: begin
        result    = {src[file_alu_pkg::MSB_POS-1:file_alu_pkg::LSB_POS], 1'b0};
        carry     = src[file_alu_pkg::MSB_POS];
        carry_upd = 1'b1;
        zero_upd  = 1'b1;
      end
      file_alu_pkg::LOGICAL_SHIFT_RIGHT_OP: begin
        result    = {1'b0, src[file_alu_pkg::MSB_POS:file_alu_pkg::LSB_POS+1]};
        carry     = src[file_alu_pkg::LSB_POS];
        carry_upd = 1'b1;
        zero_upd  = 1'b1;
      end
      file_alu_pkg::REG_MOVE_TEST_OP: begin
        result   = src;
        zero_upd = 1'b1;
      end
      default: begin
        result = src;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> core/file_reg_alu_ops.sv
/*
  Sequencer and state for five file-register operations: takes an
  operation from the decoder, reads the addressed data-memory byte,
  computes through file_alu_unit and writes the result to the
  accumulator or back to data memory, updating zero, and carry on shifts.
  Assumes data memory returns read data in the cycle after its read
  strobe, and that all inputs are synchronous to SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module file_reg_alu_ops (
  // clock, reset, enable
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // operation request from the decoder
  input  wire logic       OP_VALID,
  input  wire logic [2:0] OP_CODE,
  input  wire logic [6:0] OP_FADDR,
  input  wire logic       OP_DEST,
  output logic            OP_READY,
  output logic            OP_DONE,
  // data memory access
  output logic      [6:0] MEM_ADDR,
  output logic            MEM_RD,
  input  wire logic [7:0] MEM_RDATA,
  output logic            MEM_WR,
  output logic      [7:0] MEM_WDATA,
  // core state
  output logic      [7:0] ACC,
  output logic            CARRY,
  output logic            ZERO,
  // register port
  input  wire logic [1:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA
);

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC
  } state_t;

  state_t     state_ff;
  state_t     nxt_state;
  logic [2:0] op_ff;
  logic [6:0] faddr_ff;
  logic       dest_ff;
  logic [7:0] acc_ff;
  logic       carry_ff;
  logic       zero_ff;
  logic       done_ff;
  logic       mem_rd_ff;
  logic       mem_wr_ff;
  logic [7:0] mem_wdata_ff;
  logic [7:0] reg_rdata_ff;

  logic [7:0] alu_result;
  logic       alu_carry;
  logic       alu_carry_upd;
  logic       alu_zero_upd;
  logic       exec;
  logic       take;

  // request taken only when idle
  assign take = CE && OP_VALID && (state_ff == ST_IDLE);
  // result cycle: memory data present on MEM_RDATA
  assign exec = CE && (state_ff == ST_EXEC);

  // ---------------------------------------------------------------
  // result unit
  // ---------------------------------------------------------------
  file_alu_unit u_alu (
    .op        (op_ff),
    .acc       (acc_ff),
    .src       (MEM_RDATA),
    .result    (alu_result),
    .carry     (alu_carry),
    .carry_upd (alu_carry_upd),
    .zero_upd  (alu_zero_upd)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (OP_VALID) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_ff <= ST_IDLE;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // latch the request
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      op_ff    <= file_alu_pkg::REG_MOVE_TEST_OP;
      faddr_ff <= '0;
      dest_ff  <= file_alu_pkg::DEST_ACC;
    end else if (take) begin
      op_ff    <= OP_CODE;
      faddr_ff <= OP_FADDR;
      dest_ff  <= OP_DEST;
    end
  end

  // ---------------------------------------------------------------
  // data memory side
  // ---------------------------------------------------------------

  // read strobe in the cycle after the request
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mem_rd_ff <= 1'b0;
    end else if (CE) begin
      mem_rd_ff <= take;
    end
  end

  // write back to the file register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= file_alu_pkg::BYTE_ZERO;
    end else if (CE) begin
      mem_wr_ff <= exec && (dest_ff == file_alu_pkg::DEST_FILE) && alu_zero_upd;
      if (exec) begin
        mem_wdata_ff <= alu_result;
      end
    end
  end

  // completion pulse
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      done_ff <= 1'b0;
    end else if (CE) begin
      done_ff <= exec;
    end
  end

  // ---------------------------------------------------------------
  // accumulator and flags
  // ---------------------------------------------------------------

  // accumulator: operation result wins over a port write
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      acc_ff <= file_alu_pkg::ACC_RESET;
    end else if (CE) begin
      if (exec && (dest_ff == file_alu_pkg::DEST_ACC) && alu_zero_upd) begin
        acc_ff <= alu_result;
      end else if (REG_WR && (REG_ADDR == file_alu_pkg::REG_ACC_OFS)) begin
        acc_ff <= REG_WDATA;
      end
    end
  end

  // zero flag
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      zero_ff <= file_alu_pkg::Z_RESET;
    end else if (CE) begin
      if (exec && alu_zero_upd) begin
        zero_ff <= file_alu_pkg::is_zero(alu_result);
      end else if (REG_WR && (REG_ADDR == file_alu_pkg::REG_FLAGS_OFS)) begin
        zero_ff <= REG_WDATA[file_alu_pkg::FLAG_Z_POS];
      end
    end
  end

  // carry flag: shifts only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      carry_ff <= file_alu_pkg::C_RESET;
    end else if (CE) begin
      if (exec && alu_carry_upd) begin
        carry_ff <= alu_carry;
      end else if (REG_WR && (REG_ADDR == file_alu_pkg::REG_FLAGS_OFS)) begin
        carry_ff <= REG_WDATA[file_alu_pkg::FLAG_C_POS];
      end
    end
  end

  // ---------------------------------------------------------------
  // register port read
  // ---------------------------------------------------------------

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      reg_rdata_ff <= file_alu_pkg::BYTE_ZERO;
    end else if (CE) begin
      reg_rdata_ff <= file_alu_pkg::BYTE_ZERO;
      if (REG_RD) begin
        case (REG_ADDR)
          file_alu_pkg::REG_ACC_OFS: begin
            reg_rdata_ff <= acc_ff;
          end
          file_alu_pkg::REG_FLAGS_OFS: begin
            reg_rdata_ff[file_alu_pkg::FLAG_C_POS] <= carry_ff;
            reg_rdata_ff[file_alu_pkg::FLAG_Z_POS] <= zero_ff;
          end
          default: begin
            reg_rdata_ff <= file_alu_pkg::BYTE_ZERO;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign OP_READY  = (state_ff == ST_IDLE);
  assign OP_DONE   = done_ff;
  assign MEM_ADDR  = faddr_ff;
  assign MEM_RD    = mem_rd_ff;
  assign MEM_WR    = mem_wr_ff;
  assign MEM_WDATA = mem_wdata_ff;
  assign ACC       = acc_ff;
  assign CARRY     = carry_ff;
  assign ZERO      = zero_ff;
  assign REG_RDATA = reg_rdata_ff;

endmodule

`default_nettype wire

// >>> bench/file_reg_alu_ops_asserts.sv
/*
  Checker for the file-register operation datapath.
  Assumes binding to file_reg_alu_ops and CE held high while checked.
*/
`timescale 1ns/1ps
`default_nettype none
module file_reg_alu_ops_asserts (
  // clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic       CE,
  // operation handshake
  input wire logic       OP_VALID,
  input wire logic [2:0] OP_CODE,
  input wire logic       OP_DEST,
  input wire logic       OP_READY,
  input wire logic       OP_DONE,
  // memory and state
  input wire logic       MEM_RD,
  input wire logic [7:0] MEM_RDATA,
  input wire logic       MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic [7:0] ACC,
  input wire logic       CARRY,
  input wire logic       ZERO,
  input wire logic       REG_WR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST || !CE);
  // expected byte of a finished op
  function automatic logic [7:0] expv(logic [2:0] o, logic [7:0] a, logic [7:0] f);
    case (o)
      3'h0: expv = f + 8'h01;
      3'h1: expv = a | f;
      3'h2: expv = {f[6:0], 1'b0};
      3'h3: expv = {1'b0, f[7:1]};
      default: expv = f;
    endcase
  endfunction
  // request accepted, and a known op finishing
  sequence take;
    OP_VALID && OP_READY;
  endsequence
  sequence fin;
    OP_DONE && $past(OP_CODE, 3) <= 3'h4;
  endsequence
  a_read_strobe: assert property (take |=> MEM_RD ##1 !MEM_RD)
    else $error("read strobe shape wrong");
  a_done_time: assert property (take |=> !OP_DONE [*2] ##1 OP_DONE)
    else $error("done not three cycles after take");
  a_acc_dest: assert property (fin |-> $past(OP_DEST, 3) ||
    ACC == expv($past(OP_CODE, 3), $past(ACC), $past(MEM_RDATA)))
    else $error("accumulator result wrong");
  a_mem_dest: assert property (fin |-> !$past(OP_DEST, 3) || MEM_WR &&
    MEM_WDATA == expv($past(OP_CODE, 3), $past(ACC), $past(MEM_RDATA)))
    else $error("write back result wrong");
  a_zero_flag: assert property (fin |->
    ZERO == (expv($past(OP_CODE, 3), $past(ACC), $past(MEM_RDATA)) == 8'h00))
    else $error("zero flag wrong");
  a_carry_shift: assert property (OP_DONE && $past(OP_CODE, 3) inside {3'h2, 3'h3} |->
    CARRY == ($past(OP_CODE, 3) == 3'h2 ? $past(MEM_RDATA[7]) : $past(MEM_RDATA[0])))
    else $error("shift carry wrong");
  a_carry_kept: assert property (OP_DONE && !$past(REG_WR) &&
    $past(OP_CODE, 3) inside {3'h0, 3'h1, 3'h4} |-> $stable(CARRY))
    else $error("carry changed");
  a_acc_kept: assert property (OP_DONE && $past(OP_DEST, 3) && !$past(REG_WR) |-> $stable(ACC))
    else $error("accumulator changed");
  a_write_file_only: assert property (MEM_WR |-> OP_DONE && $past(OP_DEST, 3))
    else $error("stray memory write");
endmodule
bind file_reg_alu_ops file_reg_alu_ops_asserts chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
  .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_DEST(OP_DEST), .OP_READY(OP_READY),
  .OP_DONE(OP_DONE), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .MEM_WR(MEM_WR),
  .MEM_WDATA(MEM_WDATA), .ACC(ACC), .CARRY(CARRY), .ZERO(ZERO), .REG_WR(REG_WR));
`default_nettype wire

// >>> bench/file_mem_model.sv
/*
  Data memory model: read data valid only the cycle after the strobe.
  Assumes one clock shared with the datapath.
*/
`timescale 1ns/1ps
`default_nettype none
module file_mem_model (
  // clock
  input wire logic       clk,
  // access
  input wire logic [6:0] addr,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  output logic     [7:0] rdata
);
  logic [7:0] mem [128];
  initial rdata = 8'h00;
  // answer reads, scramble outside the valid cycle
  always @(posedge clk) begin
    if (rd) rdata <= mem[addr];
    else rdata <= ~rdata;
    if (wr) mem[addr] <= wdata;
  end
endmodule
`default_nettype wire

// >>> bench/file_reg_alu_ops_tb.sv
/*
  Testbench: runs every op, destination and edge byte, checks results.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module file_reg_alu_ops_tb;
  logic       sys_clk, rst, op_valid, op_dest, op_ready, op_done;
  logic       mem_rd, mem_wr, carry, zero, reg_wr, reg_rd, z, c;
  logic [2:0] op_code;
  logic [6:0] op_faddr, mem_addr, a;
  logic [7:0] mem_rdata, mem_wdata, acc, reg_wdata, reg_rdata, f, r;
  logic [1:0] reg_addr;
  logic [7:0] vals [3] = '{8'hFF, 8'h01, 8'h00};
  int         n_errors = 0;
  int         n_checks = 0;
  file_reg_alu_ops dut_u (.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .OP_VALID(op_valid),
    .OP_CODE(op_code), .OP_FADDR(op_faddr), .OP_DEST(op_dest), .OP_READY(op_ready),
    .OP_DONE(op_done), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
    .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .ACC(acc), .CARRY(carry), .ZERO(zero),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  file_mem_model mem_u (.clk(sys_clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr),
    .wdata(mem_wdata), .rdata(mem_rdata));
  // expected {zero, carry, result} with carry preset to one
  function automatic logic [9:0] exp_of(int o, logic [7:0] v);
    logic [7:0] q;
    logic       k;
    k = 1'b1;
    case (o)
      0: q = v + 8'h01;
      1: q = v | 8'h30;
      2: {k, q} = {v, 1'b0};
      3: {q, k} = {1'b0, v};
      4: q = v;
      default: return {2'h1, v};
    endcase
    return {q == 8'h00, k, q};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    n_checks++;
    if (v !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic reg_write(input logic [1:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [1:0] ad, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg", e, reg_rdata);
  endtask
  task automatic run_op(input logic [2:0] o, input logic [6:0] ad, input logic d);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= o;
    op_faddr <= ad;
    op_dest <= d;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 chk("ready", 8'h00, {7'h00, op_ready});
    repeat (2) @(posedge sys_clk);
    #1 chk("done", 8'h01, {7'h00, op_done});
    chk("ready", 8'h01, {7'h00, op_ready});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    results();
  end
  // main sequence
  initial begin
    {rst, op_valid, op_code, op_faddr, op_dest} = {1'b1, 12'h000};
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 12'h000;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    reg_check(2'h0, 8'h00);
    reg_check(2'h1, 8'h00);
    reg_write(2'h2, 8'hAA);
    reg_check(2'h2, 8'h00);
    reg_check(2'h3, 8'h00);
    for (int o = 0; o < 6; o++) begin
      for (int d = 0; d < 2; d++) begin
        for (int k = 0; k < 3; k++) begin
          a = 7'(o * 6 + d * 3 + k);
          f = vals[k];
          mem_u.mem[a] = f;
          reg_write(2'h0, 8'h30);
          reg_write(2'h1, 8'h01);
          run_op(3'(o), a, d[0]);
          {z, c, r} = exp_of(o, f);
          reg_check(2'h0, (d == 0 && o < 5) ? r : 8'h30);
          reg_check(2'h1, {6'h00, z, c});
          chk("mem", (d == 1 && o < 5) ? r : f, mem_u.mem[a]);
        end
      end
    end
    results();
  end
endmodule
`default_nettype wire
